// ### rtl/cda_alu.sv
// complement and decimal-adjust alu slice
`timescale 1ns/10ps
// How it works
// - in-place complement inverts every bit and writes back to same byte
// - complement_to_working_register loads inverted byte, memory left alone
// - low nibble gets plus six if above nine or half carry set
// - high nibble gets plus six if above nine after the low fix, or carry set
// - decimal adjust writes working register plus 00h/06h/60h/66h to memory
// - decimal adjust changes only carry, set when bcd sum passes 99
module cda_alu
  import cda_pkg::*;
(
  input  wire logic     mclk,
  input  wire logic     nrst,
  input  wire cda_req_t req,
  output cda_rsp_t      rsp
);

  // ****************************************************************
  // combinational datapath
  // ****************************************************************
  wire logic [CDA_W-1:0] inverted;
  wire logic [CDA_W-1:0] adj_value;
  wire logic             adj_carry;
  wire logic             is_cpl_mem;
  wire logic             is_cpl_wr;
  wire logic             is_adj;
  wire logic             inv_zero;
  cda_rsp_t              rsp_next;
  cda_rsp_t              rsp_reg;

  // operation decode, gated by the request strobe
  assign is_cpl_mem = req.valid && (req.op == CDA_OP_CPL_MEM);
  assign is_cpl_wr  = req.valid && (req.op == CDA_OP_CPL_TO_WR);
  assign is_adj     = req.valid && (req.op == CDA_OP_DEC_ADJUST);
  assign inverted   = ~req.mem_data;
  assign inv_zero   = (inverted == CDA_ZERO);

  cda_dec_adjust u_adj (
    .value         (req.working_register),
    .carry_in      (req.flags.carry),
    .half_carry_in (req.flags.half_carry_flag),
    .adjusted      (adj_value),
    .carry_out     (adj_carry)
  );

  // answer assembly; flags not written keep their incoming value
  assign rsp_next.done                  = is_cpl_mem | is_cpl_wr | is_adj;
  assign rsp_next.mem_we                = is_cpl_mem | is_adj;
  assign rsp_next.mem_wdata             = is_adj ? adj_value : (is_cpl_mem ? inverted : CDA_ZERO);
  assign rsp_next.wr_we                 = is_cpl_wr;
  assign rsp_next.wr_wdata              = is_cpl_wr ? inverted : CDA_ZERO;
  assign rsp_next.flag_we.zero_we       = is_cpl_mem | is_cpl_wr;
  assign rsp_next.flag_we.carry_we      = is_adj;
  assign rsp_next.flags.zero            = (is_cpl_mem | is_cpl_wr) ? inv_zero : req.flags.zero;
  assign rsp_next.flags.carry           = is_adj ? adj_carry : req.flags.carry;
  assign rsp_next.flags.half_carry_flag = req.flags.half_carry_flag;

  // ****************************************************************
  // output register
  // ****************************************************************
  // one register stage keeps every output straight from a flop
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rsp_reg <= '0;
    end else begin
      rsp_reg <= rsp_next;
    end
  end

  assign rsp = rsp_reg;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  sequence s_cpl_mem_req;
    req.valid && req.op == CDA_OP_CPL_MEM;
  endsequence

  sequence s_adj_req;
    req.valid && req.op == CDA_OP_DEC_ADJUST;
  endsequence

  a_cpl_mem_write: assert property (s_cpl_mem_req |=> rsp.mem_we && !rsp.wr_we
    && rsp.mem_wdata == ~$past(req.mem_data)) else $error("in-place complement wrong");

  a_cpl_wr_load: assert property (req.valid && req.op == CDA_OP_CPL_TO_WR |=> rsp.wr_we
    && !rsp.mem_we && rsp.wr_wdata == ~$past(req.mem_data))
    else $error("complement to working register wrong");

  a_low_nibble_fix: assert property (s_adj_req and
    (cda_over9(req.working_register[3:0]) || req.flags.half_carry_flag) |=>
    rsp.mem_wdata[3:0] == $past(req.working_register[3:0]) + CDA_COR_LO[3:0])
    else $error("low digit not corrected");

  a_low_nibble_pass: assert property (s_adj_req and
    !(cda_over9(req.working_register[3:0]) || req.flags.half_carry_flag) |=>
    rsp.mem_wdata[3:0] == $past(req.working_register[3:0]))
    else $error("low digit changed");

  a_high_nibble_fix: assert property (s_adj_req and req.flags.carry |=>
    rsp.flags.carry && (rsp.mem_wdata - $past(req.working_register)) inside {8'h60, 8'h66})
    else $error("high digit not corrected");

  a_adjust_const: assert property (s_adj_req |=> rsp.mem_we && !rsp.wr_we &&
    (rsp.mem_wdata - $past(req.working_register)) inside {8'h00, 8'h06, 8'h60, 8'h66})
    else $error("decimal adjust correction illegal");

  a_adjust_flags: assert property (s_adj_req |=> rsp.flag_we.carry_we && !rsp.flag_we.zero_we
    && rsp.flags.zero == $past(req.flags.zero)
    && rsp.flags.carry == ($past(req.flags.carry) || rsp.mem_wdata < $past(req.working_register)
       || (rsp.mem_wdata - $past(req.working_register)) >= CDA_COR_HI))
    else $error("decimal adjust flag effect wrong");

  a_cpl_zero_flag: assert property (s_cpl_mem_req |=> rsp.flag_we.zero_we && !rsp.flag_we.carry_we
    && rsp.flags.zero == (rsp.mem_wdata == CDA_ZERO) && rsp.flags.carry == $past(req.flags.carry))
    else $error("complement zero flag wrong");

  a_idle_quiet: assert property (!req.valid |=> !rsp.done && !rsp.mem_we && !rsp.wr_we)
    else $error("write without request");

  // ****************************************************************
  // helpers for the write-back lane checks
  // ****************************************************************
  // correction really applied by an adjust; wraps modulo 256 on purpose
  function automatic logic [CDA_W-1:0] cda_applied(input logic [CDA_W-1:0] after_val,
                                                    input logic [CDA_W-1:0] before_val);
    return after_val - before_val;
  endfunction

  sequence s_cpl_wr_req;
    req.valid && req.op == CDA_OP_CPL_TO_WR;
  endsequence

  sequence s_none_req;
    req.valid && req.op == CDA_OP_NONE;
  endsequence

  // a decimal adjust on two digits that are already clean, no carry or half carry set
  sequence s_adj_clean;
    s_adj_req ##0 (!req.flags.carry && !req.flags.half_carry_flag
      && !cda_over9(req.working_register[7:4]) && !cda_over9(req.working_register[3:0]));
  endsequence

  // low digit overflow that ripples into a high digit of nine
  sequence s_adj_ripple;
    s_adj_req ##0 (req.working_register[7:4] == CDA_NIB_MAX
      && cda_over9(req.working_register[3:0]));
  endsequence

  // high digit already past nine before any correction
  sequence s_adj_high_over;
    s_adj_req ##0 cda_over9(req.working_register[7:4]);
  endsequence

  // ****************************************************************
  // checks on the write-back lanes
  // ****************************************************************
  // complement to the working register raises zero from its own result
  a_cpl_wr_zero: assert property (s_cpl_wr_req |=> rsp.flag_we.zero_we && !rsp.flag_we.carry_we
    && rsp.flags.zero == (rsp.wr_wdata == CDA_ZERO) && rsp.flags.carry == $past(req.flags.carry))
    else $error("complement to working register zero flag wrong");

  // memory lane stays idle so the addressed byte is left as it was
  a_cpl_wr_no_mem: assert property (s_cpl_wr_req |=> rsp.done && !rsp.mem_we
    && rsp.mem_wdata == CDA_ZERO)
    else $error("complement to working register touched memory");

  // in-place complement never loads the working register
  a_cpl_mem_no_wr: assert property (s_cpl_mem_req |=> rsp.done && !rsp.wr_we
    && rsp.wr_wdata == CDA_ZERO)
    else $error("in-place complement touched working register");

  // adjust never loads the working register either
  a_adjust_no_wr: assert property (s_adj_req |=> rsp.done && !rsp.wr_we
    && rsp.wr_wdata == CDA_ZERO)
    else $error("decimal adjust touched working register");

  // clean digits pass untouched and produce no carry
  a_adjust_clean: assert property (s_adj_clean |=>
    rsp.mem_wdata == $past(req.working_register) && !rsp.flags.carry)
    else $error("clean digits were corrected");

  // a ripple out of the low digit must still fix the high digit
  a_ripple_fix: assert property (s_adj_ripple |=> rsp.flags.carry
    && cda_applied(rsp.mem_wdata, $past(req.working_register)) == (CDA_COR_LO | CDA_COR_HI))
    else $error("ripple into high digit not corrected");

  // a high digit above nine always carries into the next byte
  a_high_over_carry: assert property (s_adj_high_over |=> rsp.flags.carry
    && cda_applied(rsp.mem_wdata, $past(req.working_register)) >= CDA_COR_HI)
    else $error("high digit above nine gave no carry");

  // half carry is never written by this slice
  a_half_carry_kept: assert property (req.valid |=>
    rsp.flags.half_carry_flag == $past(req.flags.half_carry_flag))
    else $error("half carry flag changed");

  // at most one flag written per operation
  a_flag_we_single: assert property (!(rsp.flag_we.zero_we && rsp.flag_we.carry_we))
    else $error("two flags written at once");

  // a strobe with no operation code writes nothing and passes flags
  a_refused_op: assert property (s_none_req |=> !rsp.done && !rsp.mem_we && !rsp.wr_we
    && rsp.flag_we == '0 && rsp.flags == $past(req.flags))
    else $error("refused request had an effect");

  // data lanes read zero without a request, so stale data never leaks
  a_idle_data: assert property (!req.valid |=> rsp.mem_wdata == CDA_ZERO
    && rsp.wr_wdata == CDA_ZERO && rsp.flag_we == '0)
    else $error("data lane busy without request");

  // done goes with exactly one write enable, never both lanes at once
  a_done_match: assert property (rsp.done == (rsp.mem_we || rsp.wr_we)
    && !(rsp.mem_we && rsp.wr_we))
    else $error("done and write enables disagree");

endmodule

// ### rtl/cda_dec_adjust.sv
// decimal-adjust correction: picks 00h/06h/60h/66h and forms the sum
`timescale 1ns/10ps
module cda_dec_adjust
  import cda_pkg::*;
(
  input  wire logic [CDA_W-1:0] value,
  input  wire logic             carry_in,
  input  wire logic             half_carry_in,
  output logic      [CDA_W-1:0] adjusted,
  output logic                  carry_out
);

  // ****************************************************************
  // correction selection
  // ****************************************************************
  wire logic             lo_fix;
  wire logic [CDA_W:0]   lo_sum;
  wire logic             hi_fix;
  wire logic [CDA_W-1:0] correction;
  wire logic [CDA_W:0]   full_sum;

  // low digit fix on overflow or half carry
  assign lo_fix     = cda_over9(value[3:0]) | half_carry_in;
  assign lo_sum     = {1'b0, value} + {1'b0, (lo_fix ? CDA_COR_LO : CDA_ZERO)};
  // high digit judged after the low fix, so a ripple like 9Ah still corrects
  assign hi_fix     = cda_over9(lo_sum[7:4]) | lo_sum[CDA_W] | carry_in;
  assign correction = (lo_fix ? CDA_COR_LO : CDA_ZERO) | (hi_fix ? CDA_COR_HI : CDA_ZERO);
  assign full_sum   = {1'b0, value} + {1'b0, correction};
  assign adjusted   = full_sum[CDA_W-1:0];
  // a high fix means the decimal sum passed 99: carry chains multi-byte adds
  assign carry_out  = hi_fix | full_sum[CDA_W];

endmodule

// ### rtl/cda_pkg.sv
// shared types and constants, plus the bcd digit check used by the decimal adjust
package cda_pkg;

  // ****************************************************************
  // widths and correction constants
  // ****************************************************************
  localparam int unsigned    CDA_W       = 8;
  localparam logic [3:0]     CDA_NIB_MAX = 4'h9;   // largest legal bcd digit
  localparam logic [7:0]     CDA_COR_LO  = 8'h06;
  localparam logic [7:0]     CDA_COR_HI  = 8'h60;
  localparam logic [7:0]     CDA_ZERO    = 8'h00;
  localparam int unsigned    CDA_LATENCY = 1;      // request edge to answer

  // ****************************************************************
  // operation codes
  // ****************************************************************
  typedef enum logic [1:0] {
    CDA_OP_NONE       = 2'b00,
    CDA_OP_CPL_MEM    = 2'b01,   // complement memory byte in place
    CDA_OP_CPL_TO_WR  = 2'b10,   // complement_to_working_register
    CDA_OP_DEC_ADJUST = 2'b11    // decimal_adjust_to_memory
  } cda_op_t;

  // status flags as seen by this slice
  typedef struct packed {
    logic carry;
    logic half_carry_flag;
    logic zero;
  } cda_flags_t;

  // per-flag write enables toward the flag register
  typedef struct packed {
    logic carry_we;
    logic zero_we;
  } cda_flag_we_t;

  // request from the sequencer
  typedef struct packed {
    logic               valid;
    cda_op_t            op;
    logic [CDA_W-1:0]   mem_data;
    logic [CDA_W-1:0]   working_register;
    cda_flags_t         flags;
  } cda_req_t;

  // write-backs toward memory, working register and flags
  typedef struct packed {
    logic               done;
    logic               mem_we;
    logic [CDA_W-1:0]   mem_wdata;
    logic               wr_we;
    logic [CDA_W-1:0]   wr_wdata;
    cda_flag_we_t       flag_we;
    cda_flags_t         flags;
  } cda_rsp_t;

  // bcd digit above nine
  function automatic logic cda_over9(input logic [3:0] nib);
    return nib > CDA_NIB_MAX;
  endfunction

endpackage

// ### verif/cda_seq_model.sv
// sequencer-side model: data memory byte and working register fed by write-backs
`timescale 1ns/10ps
module cda_seq_model
  import cda_pkg::*;
(
  input  wire logic             mclk,
  input  wire logic             nrst,
  input  wire cda_rsp_t         rsp,
  output logic      [CDA_W-1:0] mem_byte,
  output logic      [CDA_W-1:0] wr_reg
);
  // ****************************************************************
  // commit only what is enabled, so a stray write shows up later
  // ****************************************************************
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      mem_byte <= 8'h00;
      wr_reg   <= 8'h00;
    end else begin
      if (rsp.mem_we) mem_byte <= rsp.mem_wdata;
      if (rsp.wr_we) wr_reg <= rsp.wr_wdata;
    end
  end
endmodule

// ### verif/testbench.sv
// self-checking bench for the complement and decimal-adjust slice
`timescale 1ns/10ps
module testbench;
  import cda_pkg::*;
  // ****************************************************************
  // signals and stimulus tables
  // ****************************************************************
  logic             mclk;
  logic             nrst;
  cda_req_t         req;
  cda_rsp_t         rsp;
  logic [CDA_W-1:0] mem_byte;
  logic [CDA_W-1:0] wr_reg;
  int               errors;
  int               samples_checked;
  int               cycles;
  // {0, carry, half carry, zero, working register}
  localparam logic [11:0] ADJ_CASES [7] = '{12'h09A, 12'h145, 12'h00A, 12'h212, 12'h480, 12'h699, 12'h09F};

  cda_alu DUT (.mclk(mclk), .nrst(nrst), .req(req), .rsp(rsp));
  cda_seq_model model (.mclk(mclk), .nrst(nrst), .rsp(rsp), .mem_byte(mem_byte), .wr_reg(wr_reg));

  // clock and a hang limit well above the few dozen cycles needed
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      results();
    end
  end

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one request, answer sampled 1 ns after the edge that takes it
  task automatic send(input cda_op_t op, input logic [7:0] m, input logic v, input logic [2:0] f);
    @(posedge mclk);
    req <= '{v, op, m, 8'h3C, f};
    @(posedge mclk);
    req.valid <= 1'b0;
    #1;
  endtask
  function automatic cda_rsp_t exp_adj(input logic [11:0] c);
    logic [8:0] t;
    logic       hi;
    cda_rsp_t   e;
    t = {1'b0, c[7:0]} + ((c[3:0] > 4'h9 || c[9]) ? 9'h006 : 9'h000);
    hi = t[8] || t[7:4] > 4'h9 || c[10];
    e = '0;
    e.done = 1'b1;
    e.mem_we = 1'b1;
    e.mem_wdata = t[7:0] + (hi ? 8'h60 : 8'h00);
    e.flag_we.carry_we = 1'b1;
    e.flags = {hi, c[9], c[8]};
    return e;
  endfunction

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic test_complement;
    send(CDA_OP_CPL_MEM, 8'hFF, 1'b1, 3'b110);
    chk(rsp, {2'b11, 8'h00, 9'h000, 2'b01, 3'b111});
    send(CDA_OP_CPL_MEM, 8'h5A, 1'b1, 3'b001);
    chk(rsp, {2'b11, 8'hA5, 9'h000, 2'b01, 3'b000});
    send(CDA_OP_CPL_TO_WR, 8'h0F, 1'b1, 3'b101);
    chk(rsp, {10'h200, 1'b1, 8'hF0, 2'b01, 3'b100});
    send(CDA_OP_CPL_TO_WR, 8'hFF, 1'b1, 3'b010);
    chk(rsp, {10'h200, 1'b1, 8'h00, 2'b01, 3'b011});
    #10;
    chk({8'h00, mem_byte, wr_reg}, {8'h00, 8'hA5, 8'h00});
    $display("test complement done");
  endtask
  // requests back to back, each answer checked while the next is taken
  task automatic test_decimal;
    for (int i = 0; i <= 7; i++) begin
      @(posedge mclk);
      if (i < 7) req <= '{1'b1, CDA_OP_DEC_ADJUST, 8'h5A, ADJ_CASES[i][7:0], ADJ_CASES[i][10:8]};
      else req.valid <= 1'b0;
      #1;
      if (i > 0) chk(rsp, exp_adj(ADJ_CASES[i-1]));
    end
    $display("test decimal done");
  endtask
  // no operation code or no strobe: flags only pass through
  task automatic test_refused;
    send(CDA_OP_NONE, 8'hFF, 1'b1, 3'b101);
    chk(rsp, {21'h0, 3'b101});
    send(CDA_OP_DEC_ADJUST, 8'hFF, 1'b0, 3'b010);
    chk(rsp, {21'h0, 3'b010});
    $display("test refused done");
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // reset, then scenarios in turn
  initial begin
    errors = 0;
    samples_checked = 0;
    cycles = 0;
    nrst = 1'b0;
    req = '0;
    repeat (20) @(posedge mclk);
    chk(rsp, 24'h000000);
    nrst <= 1'b1;
    test_complement();
    test_decimal();
    test_refused();
    results();
  end
endmodule
